// >>> shared/dpt_regs.svh
// Constants of the two-wire digital potentiometer slave
`ifndef DPT_REGS_SVH
`define DPT_REGS_SVH

// Device type nibble of the slave address (arbitrary value)
`define DPT_DEVICE_TYPE 4'h3

// Instruction opcodes in the top nibble of the instruction byte
`define DPT_OP_RD_WIPER 4'h9
`define DPT_OP_WR_WIPER 4'hA
`define DPT_OP_RD_DATA 4'hB
`define DPT_OP_WR_DATA 4'hC
`define DPT_OP_XFR_TO_WIPER 4'hD
`define DPT_OP_XFR_TO_DATA 4'hE

// Field positions in the slave address and instruction bytes
`define DPT_ADDR_GND_BIT 3
`define DPT_INSTR_OP_MSB 7
`define DPT_INSTR_OP_LSB 4

// Reset values
`define DPT_WIPER_RESET 8'h00
`define DPT_DATA_RESET 8'h00

// Non-volatile write time in microseconds and the system clock rate
`define DPT_NV_WRITE_TIME_US 5000
`define DPT_CLK_SYS_MHZ 100

`endif

// >>> shared/dpt_pkg.sv
// Types of the two-wire digital potentiometer slave
package dpt_pkg;

	typedef enum logic [2:0] {ST_RECALL, ST_IDLE, ST_ADDR, ST_INSTR, ST_WDATA, ST_RLOAD, ST_RDATA, ST_IGNORE} dpt_state_e;

	typedef logic [7:0] dpt_byte_t;

	typedef struct packed {
		logic [4:0] pin_s1;
		logic [4:0] pin_s2;
		logic [1:0] scl_sync;
		logic [1:0] sda_sync;
		logic scl_p;
		logic sda_p;
		dpt_state_e state;
		logic [3:0] cnt;
		dpt_byte_t shreg;
		dpt_byte_t instr;
		dpt_byte_t wiper;
		logic [15:0][7:0] nv;
		logic nv_pend;
		logic [3:0] nv_idx;
		dpt_byte_t nv_data;
		logic [19:0] busy_cnt;
		logic drive;
		logic active;
	} dpt_state_s;

	typedef struct packed {
		logic [255:0] tap;
	} dpt_tap_s;

endpackage : dpt_pkg

// >>> logic/dpt_tap_decoder.sv
// One-hot decoder from wiper position to the 256 tap switches
`include "dpt_regs.svh"
module dpt_tap_decoder
	import dpt_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] wiper_position,
	output logic [255:0] tap_select
);

	dpt_tap_s s_q;
	dpt_tap_s s_d;
	logic [255:0] tap_dec;

	genvar i;
	generate
		for (i = 0; i < 256; i++)
		begin : g_tap
			assign tap_dec[i] = (wiper_position == 8'(i));
		end
	endgenerate

	always_comb
	begin
		s_d.tap = tap_dec;
		// Reset still shows exactly one switch, the one of the reset wiper value
		if (rst)
		begin
			s_d.tap = '0;
			s_d.tap[`DPT_WIPER_RESET] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		s_q <= s_d;
	end

	assign tap_select = s_q.tap;

endmodule : dpt_tap_decoder

// >>> logic/dpt_slave.sv
// Two-wire slave front end and register store of a 256-tap potentiometer
`include "dpt_regs.svh"

// Behaviour
// - Wiper register selects one of 256 taps
// - Reset recalls default saved setting into wiper
// - Master reads and writes wiper and stores
// - Sixteen non-volatile stored wiper positions
// - Write, read and transfer instructions supported
// - Sample data bits on serial clock rise
// - Change returned data after serial clock fall
// - Data line driven open-drain only
// - Address low bits from board inputs
// - Act only on matching slave address
// - Write lock low refuses non-volatile writes
// - Acknowledge address, valid instruction and write data bytes
// - Busy after stop that ends a store write; address not acknowledged
// - Exactly one tap switch on
module dpt_slave
	import dpt_pkg::*;
#(
	parameter int NV_WRITE_CYCLES = `DPT_NV_WRITE_TIME_US * `DPT_CLK_SYS_MHZ
)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_link,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	input wire logic [2:0] board_address_inputs,
	input wire logic grounded_address_input,
	input wire logic nv_write_lock_n,
	output logic [7:0] wiper_position,
	output logic nv_busy,
	output logic [255:0] tap_select
);

	dpt_state_s s_q;
	dpt_state_s s_d;
	logic link_drive_q;
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic busy;
	logic wp_n_s;
	logic [3:0] addr_s;
	dpt_byte_t byte_in;
	logic [3:0] op;

	function automatic logic [3:0] reg_index(input dpt_byte_t ins);
		return {ins[1], ins[0], ins[3], ins[2]};
	endfunction : reg_index

	function automatic logic in_bank0(input dpt_byte_t ins);
		return ins[1:0] == 2'h0;
	endfunction : in_bank0

	assign scl_s = s_q.scl_sync[1];
	assign sda_s = s_q.sda_sync[1];
	assign scl_rise = scl_s & ~s_q.scl_p;
	assign scl_fall = ~scl_s & s_q.scl_p;
	assign start_c = scl_s & s_q.scl_p & s_q.sda_p & ~sda_s;
	assign stop_c = scl_s & s_q.scl_p & ~s_q.sda_p & sda_s;
	assign busy = s_q.busy_cnt != '0;
	assign wp_n_s = s_q.pin_s2[4];
	assign addr_s = s_q.pin_s2[3:0];
	assign byte_in = {s_q.shreg[6:0], sda_s};
	assign op = s_q.instr[`DPT_INSTR_OP_MSB:`DPT_INSTR_OP_LSB];

	always_comb
	begin
		s_d = s_q;
		s_d.pin_s1 = {nv_write_lock_n, grounded_address_input, board_address_inputs};
		s_d.pin_s2 = s_q.pin_s1;
		s_d.scl_sync = {s_q.scl_sync[0], scl_link};
		s_d.sda_sync = {s_q.sda_sync[0], sda_i};
		s_d.scl_p = scl_s;
		s_d.sda_p = sda_s;
		if (busy)
		begin
			s_d.busy_cnt = s_q.busy_cnt - 20'd1;
		end
		if (s_q.state == ST_RECALL)
		begin
			s_d.wiper = s_q.nv[0];
			s_d.state = ST_IDLE;
		end
		else if (stop_c)
		begin
			s_d.state = ST_IDLE;
			s_d.drive = 1'b0;
			s_d.active = 1'b0;
			if (s_q.nv_pend)
			begin
				// Store lands at once; busy time models the cell programming
				s_d.nv[s_q.nv_idx] = s_q.nv_data;
				s_d.nv_pend = 1'b0;
				s_d.busy_cnt = 20'(NV_WRITE_CYCLES);
			end
		end
		else if (start_c)
		begin
			s_d.state = ST_ADDR;
			s_d.cnt = '0;
			s_d.drive = 1'b0;
			// Pin stays released until the link flop has taken the cleared drive level
			s_d.active = 1'b0;
			s_d.nv_pend = 1'b0;
		end
		else if (scl_rise && s_q.state != ST_IDLE)
		begin
			if (s_q.cnt == 4'd8)
			begin
				s_d.cnt = '0;
				s_d.drive = 1'b0;
				if (s_q.state == ST_RLOAD)
				begin
					s_d.shreg = (op == `DPT_OP_RD_WIPER) ? s_q.wiper : s_q.nv[reg_index(s_q.instr)];
					s_d.drive = ~s_d.shreg[7];
					s_d.state = ST_RDATA;
				end
				else if (s_q.state == ST_RDATA)
				begin
					s_d.state = ST_IGNORE;
				end
			end
			else
			begin
				s_d.cnt = s_q.cnt + 4'd1;
				if (s_q.state == ST_RDATA)
				begin
					// Next bit is queued here and reaches the pin at the coming fall
					s_d.drive = (s_q.cnt == 4'd7) ? 1'b0 : ~s_q.shreg[6];
					s_d.shreg = {s_q.shreg[6:0], 1'b0};
				end
				else
				begin
					s_d.shreg = byte_in;
				end
				if (s_q.cnt == 4'd7)
				begin
					unique case (s_q.state)
						ST_ADDR:
						begin
							// Busy device stays silent so the master can poll
							if (byte_in[7:4] == `DPT_DEVICE_TYPE && byte_in[3:0] == addr_s && !busy)
							begin
								s_d.drive = 1'b1;
								s_d.state = ST_INSTR;
							end
							else
							begin
								s_d.state = ST_IGNORE;
							end
						end
						ST_INSTR:
						begin
							s_d.instr = byte_in;
							s_d.drive = 1'b1;
							s_d.state = ST_IGNORE;
							unique case (byte_in[`DPT_INSTR_OP_MSB:`DPT_INSTR_OP_LSB])
								`DPT_OP_RD_WIPER, `DPT_OP_RD_DATA: s_d.state = ST_RLOAD;
								`DPT_OP_WR_WIPER, `DPT_OP_WR_DATA: s_d.state = ST_WDATA;
								`DPT_OP_XFR_TO_WIPER:
								begin
									if (in_bank0(byte_in))
									begin
										s_d.wiper = s_q.nv[reg_index(byte_in)];
									end
								end
								`DPT_OP_XFR_TO_DATA:
								begin
									if (in_bank0(byte_in) && wp_n_s)
									begin
										s_d.nv_pend = 1'b1;
										s_d.nv_idx = reg_index(byte_in);
										s_d.nv_data = s_q.wiper;
									end
								end
								default: s_d.drive = 1'b0;
							endcase
						end
						ST_WDATA:
						begin
							s_d.drive = 1'b1;
							s_d.state = ST_IGNORE;
							if (op == `DPT_OP_WR_WIPER)
							begin
								s_d.wiper = byte_in;
							end
							else if (wp_n_s)
							begin
								s_d.nv_pend = 1'b1;
								s_d.nv_idx = reg_index(s_q.instr);
								s_d.nv_data = byte_in;
							end
						end
						default:
						begin
						end
					endcase
				end
			end
		end
		// The first fall of a frame has loaded the link flop, so the pin may follow it
		if (scl_fall && s_q.state != ST_IDLE && s_q.state != ST_RECALL)
		begin
			s_d.active = 1'b1;
		end
		if (rst)
		begin
			// Stores are non-volatile and keep their contents across reset
			s_d = '0;
			s_d.nv = s_q.nv;
			s_d.wiper = `DPT_WIPER_RESET;
			s_d.state = ST_RECALL;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		s_q <= s_d;
	end

	// The drive level settles a few system clocks after a rise, long before the fall that samples it
	always_ff @(negedge scl_link)
	begin
		link_drive_q <= s_q.drive;
	end

	assign sda_o = 1'b0;
	assign sda_oe = link_drive_q & s_q.active;
	assign wiper_position = s_q.wiper;
	assign nv_busy = busy;

	dpt_tap_decoder u_tap (
		.clk_sys(clk_sys),
		.rst(rst),
		.wiper_position(s_q.wiper),
		.tap_select(tap_select)
	);

endmodule : dpt_slave

// >>> dv/dpt_slave_asserts.sv
// Port checks for the potentiometer slave
module dpt_slave_asserts #(parameter int NV_WRITE_CYCLES = 50)
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic scl_link,
	input wire logic sda_o,
	input wire logic sda_oe,
	input wire logic [7:0] wiper_position,
	input wire logic nv_busy,
	input wire logic [255:0] tap_select
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// Stored settings power up unknown, so tap checks wait for the wiper write of the third acknowledge
	logic [1:0] acks_q = 2'd0;
	logic oe_p = 1'b0;
	int cnt_q;
	always @(posedge clk_sys)
	begin
		oe_p <= sda_oe;
		if (sda_oe && !oe_p && acks_q != 2'd3)
			acks_q <= acks_q + 2'd1;
	end
	always_ff @(posedge clk_sys)
		cnt_q <= (rst || !nv_busy) ? 0 : cnt_q + 1;
	open_drain_a: assert property (sda_o == 1'b0)
		else $error("sda_o high");
	one_tap_a: assert property (acks_q == 2'd3 |-> $onehot(tap_select))
		else $error("taps not one-hot");
	tap_follow_a: assert property (acks_q == 2'd3 |-> tap_select == (256'h1 << $past(wiper_position)))
		else $error("tap mismatch");
	busy_hold_a: assert property (nv_busy && $past(nv_busy) |-> $stable(wiper_position))
		else $error("wiper moved");
	busy_len_a: assert property ($fell(nv_busy) |-> cnt_q inside {[NV_WRITE_CYCLES - 1:NV_WRITE_CYCLES + 1]})
		else $error("store time");
	busy_mute_a: assert property (nv_busy |-> !sda_oe)
		else $error("ack while busy");
	oe_rise_a: assert property ($rose(sda_oe) |-> !scl_link)
		else $error("drive in high");
	oe_steady_a: assert property (scl_link && $past(scl_link) |-> $stable(sda_oe))
		else $error("change in high");
	ack_c: cover property ($rose(sda_oe));
	store_c: cover property ($fell(nv_busy));
	wiper_c: cover property ($changed(wiper_position));
endmodule : dpt_slave_asserts
bind dpt_slave dpt_slave_asserts #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (.clk_sys(clk_sys), .rst(rst),
	.scl_link(scl_link), .sda_o(sda_o), .sda_oe(sda_oe), .wiper_position(wiper_position),
	.nv_busy(nv_busy), .tap_select(tap_select));

// >>> dv/dpt_master.sv
// Bus master model; the serial clock stands high between frames
module dpt_master #(parameter int Q = 48)
(
	output logic scl_link,
	output logic sda_pull,
	input wire logic sda_i
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		scl_link = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic bitx(input logic v, output logic s);
		sda_pull = !v;
		#Q scl_link = 1'b1;
		#Q s = sda_i;
		#Q scl_link = 1'b0;
		#Q;
	endtask : bitx
	task automatic start();
		#Q sda_pull = 1'b1;
		#Q scl_link = 1'b0;
		#Q;
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		#Q scl_link = 1'b1;
		#Q sda_pull = 1'b0;
		#(2 * Q);
	endtask : stop
	task automatic bio(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bitx(tx[i], rx[i]);
		bitx(1'b1, s);
		ack = !s;
	endtask : bio
endmodule : dpt_master

// >>> dv/two_wire_digital_pot_slave_tb_top.sv
// Bench for the potentiometer slave
module two_wire_digital_pot_slave_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, rst, scl_link, sda_i, sda_o, sda_oe, m_pull, lock_n, nv_busy;
	logic [2:0] brd, k;
	logic [7:0] wiper_position, r;
	logic [255:0] tap_select;
	int num_errors = 0;
	int n_tests = 0;
	assign sda_i = !(sda_oe || m_pull);
	dpt_slave #(.NV_WRITE_CYCLES(300)) u_dut (.clk_sys(clk_sys), .rst(rst), .scl_link(scl_link), .sda_i(sda_i),
		.sda_o(sda_o), .sda_oe(sda_oe), .board_address_inputs(brd), .grounded_address_input(1'b0),
		.nv_write_lock_n(lock_n), .wiper_position(wiper_position), .nv_busy(nv_busy), .tap_select(tap_select));
	dpt_master u_mst (.scl_link(scl_link), .sda_pull(m_pull), .sda_i(sda_i));
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = !clk_sys;
	end
	task automatic chk(input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e)
			$display("mismatch t=%0t exp=%h got=%h", $time, e, g);
		num_errors += int'(g !== e);
	endtask : chk
	task automatic final_report();
		$display("compares %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : final_report
	task automatic fr(input logic [7:0] a, input logic [7:0] i, input logic [7:0] d, input int n);
		k = 3'h0;
		u_mst.start();
		u_mst.bio(a, r, k[2]);
		if (n > 1)
			u_mst.bio(i, r, k[1]);
		if (n > 2)
			u_mst.bio(d, r, k[0]);
		u_mst.stop();
	endtask : fr
	task automatic nv_wait();
		for (int j = 0; j < 900 && nv_busy !== 1'b0; j++)
			@(negedge clk_sys);
		if (nv_busy !== 1'b0)
		begin
			$display("mismatch t=%0t exp=%h got=%h", $time, 1'b0, nv_busy);
			num_errors++;
			final_report();
		end
	endtask : nv_wait
	task automatic t_wiper();
		fr(8'h32, 8'hA0, 8'h5A, 3);
		chk(8'h07, {5'h0, k});
		chk(8'h5A, wiper_position);
		chk(8'h01, {7'h0, tap_select[90]});
		fr(8'h32, 8'h90, 8'hFF, 3);
		chk(8'h5A, r);
		$display("wiper test end");
	endtask : t_wiper
	task automatic t_addr();
		logic [7:0] bad [3] = '{8'h35, 8'h72, 8'h3A};
		foreach (bad[j])
		begin
			fr(bad[j], 8'hA0, 8'h11, 3);
			chk(8'h00, {5'h0, k});
		end
		fr(8'h32, 8'h50, 8'h00, 2);
		chk(8'h04, {5'h0, k});
		chk(8'h5A, wiper_position);
		@(negedge clk_sys) brd = 3'h5;
		fr(8'h35, 8'hA0, 8'h22, 3);
		chk(8'h22, wiper_position);
		@(negedge clk_sys) brd = 3'h2;
		$display("address test end");
	endtask : t_addr
	task automatic t_store();
		fr(8'h32, 8'hC7, 8'hC3, 3);
		chk(8'h01, {7'h0, nv_busy});
		fr(8'h32, 8'h00, 8'h00, 1);
		chk(8'h00, {5'h0, k});
		nv_wait();
		fr(8'h32, 8'hB7, 8'hFF, 3);
		chk(8'hC3, r);
		@(negedge clk_sys) lock_n = 1'b0;
		fr(8'h32, 8'hC7, 8'h77, 3);
		nv_wait();
		fr(8'h32, 8'hB7, 8'hFF, 3);
		chk(8'hC3, r);
		@(negedge clk_sys) lock_n = 1'b1;
		$display("store test end");
	endtask : t_store
	task automatic t_xfer();
		fr(8'h32, 8'hE4, 8'h00, 2);
		nv_wait();
		fr(8'h32, 8'hA0, 8'h01, 3);
		fr(8'h32, 8'hD4, 8'h00, 2);
		chk(8'h22, wiper_position);
		fr(8'h32, 8'hC0, 8'h9C, 3);
		nv_wait();
		@(negedge clk_sys) rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk(8'h9C, wiper_position);
		$display("transfer test end");
	endtask : t_xfer
	initial
	begin
		rst = 1'b1;
		brd = 3'h2;
		lock_n = 1'b1;
		repeat (5) @(negedge clk_sys);
		rst = 1'b0;
		repeat (4) @(negedge clk_sys);
		t_wiper();
		t_addr();
		t_store();
		t_xfer();
		final_report();
	end
endmodule : two_wire_digital_pot_slave_tb_top
